// File: rtl/fifo_stack_host_pkg.sv
// Package with constants and carrier types for the FIFO stack host controller.
package fifo_stack_host_pkg;

  // Device geometry of the whole stack.
  localparam int WORD_WIDTH       = 8;
  localparam int STACK_COLUMNS    = 2;
  localparam int DEVICE_WORDS     = 32;
  localparam int CASCADE_DEVICES  = 4;

  // Clock and timing figures.
  localparam int CLK_PERIOD_NS    = 4;
  localparam int DATA_HOLD_NS     = 400;
  localparam int LOAD_HIGH_NS     = 100;
  localparam int DUMP_HIGH_NS     = 100;
  localparam int DUMP_LOW_NS      = 100;

  // Least times round up to whole cycles.
  localparam int DATA_HOLD_CYCLES = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_HIGH_CYCLES = (LOAD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUMP_HIGH_CYCLES = (DUMP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUMP_LOW_CYCLES  = (DUMP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_WIDTH      = 9;

  // Words a cascade of n devices can hold.
  localparam int STACK_CAPACITY   = (DEVICE_WORDS - 1) * CASCADE_DEVICES + 1;

  // Buffer in the input path.
  localparam int BUFFER_DEPTH     = 8;

  // Input-ready polarity of the inverted-ready device variant.
  localparam logic INPUT_READY_ACTIVE = 1'b0;

  typedef logic [WORD_WIDTH-1:0] word_type;

  typedef struct packed {
    logic     valid;
    word_type data;
  } stream_word_type;

  typedef enum logic [2:0] {
    LOAD_IDLE,
    LOAD_STROBE,
    LOAD_HOLD,
    LOAD_WAIT_BUSY
  } load_state_type;

  typedef enum logic [1:0] {
    DUMP_IDLE,
    DUMP_OFFER,
    DUMP_HIGH,
    DUMP_LOW
  } dump_state_type;

endpackage

// File: rtl/word_buffer.sv
// Parameterised valid/ready FIFO buffer that stages words for the stack.
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PTR_WIDTH = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0]     store [DEPTH];
  logic [PTR_WIDTH-1:0] wr_ptr;
  logic [PTR_WIDTH-1:0] rd_ptr;
  logic [PTR_WIDTH:0]   count;
  logic [PTR_WIDTH-1:0] next_wr_ptr;
  logic [PTR_WIDTH-1:0] next_rd_ptr;
  logic [PTR_WIDTH:0]   next_count;
  logic                 push;
  logic                 pop;

  function automatic logic [PTR_WIDTH-1:0] advance(input logic [PTR_WIDTH-1:0] ptr);
    if (ptr == PTR_WIDTH'(DEPTH - 1)) begin
      advance = '0;
    end else begin
      advance = ptr + 1'b1;
    end
  endfunction

  assign in_ready  = (count != (PTR_WIDTH + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? advance(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? advance(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

endmodule

// File: rtl/fifo_stack_host.sv
// Host controller that loads and dumps a side-by-side stack of cascaded FIFO devices.
// Notes on behaviour
// - Devices within each column are chained output-valid to load and dump to input-ready, outside this block.
// - Columns are independent except for one shared load strobe and one shared dump strobe.
// - The stack is ready only while the load strobe is low and every column reports input-ready.
// - Input data stays on the pins until every column's input-ready has gone busy.
// - The host detects all-ready and then holds data for the worst-case time.
// - Input data is held for at least 400 ns after the rising load edge.
// - Input data changes only after the falling edge of the load strobe.
// - The dump strobe is issued only when all columns show output-valid and the system took the word.
`timescale 1ns/1ps
module fifo_stack_host #(
  parameter int COLUMNS = fifo_stack_host_pkg::STACK_COLUMNS,
  parameter int WIDTH   = fifo_stack_host_pkg::WORD_WIDTH,
  parameter int DEPTH   = fifo_stack_host_pkg::BUFFER_DEPTH
) (
  // Clock and reset.
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // Source side of the system.
  input  wire logic                     src_valid,
  output logic                          src_ready,
  input  wire logic [WIDTH-1:0]         src_data,
  // Sink side of the system.
  output logic                          sink_valid,
  input  wire logic                     sink_ready,
  output logic [WIDTH-1:0]              sink_data,
  // Stack input pins.
  output logic                          parallel_load_strobe,
  output logic [COLUMNS*WIDTH-1:0]      stack_in_data,
  input  wire logic [COLUMNS-1:0]       input_ready_flag_n,
  // Stack output pins.
  output logic                          word_dump_strobe,
  input  wire logic [COLUMNS-1:0]       output_valid,
  input  wire logic [COLUMNS*WIDTH-1:0] stack_out_data,
  // Status.
  output logic                          load_busy
);

  localparam logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] HOLD_COUNT =
    fifo_stack_host_pkg::TIMER_WIDTH'(fifo_stack_host_pkg::DATA_HOLD_CYCLES);
  localparam logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] LOAD_HIGH_COUNT =
    fifo_stack_host_pkg::TIMER_WIDTH'(fifo_stack_host_pkg::LOAD_HIGH_CYCLES);
  localparam logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] DUMP_HIGH_COUNT =
    fifo_stack_host_pkg::TIMER_WIDTH'(fifo_stack_host_pkg::DUMP_HIGH_CYCLES);
  localparam logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] DUMP_LOW_COUNT =
    fifo_stack_host_pkg::TIMER_WIDTH'(fifo_stack_host_pkg::DUMP_LOW_CYCLES);
  localparam int                   OCC_WIDTH = $clog2(DEPTH) + 1;
  localparam logic [OCC_WIDTH-1:0] OCC_FULL  = OCC_WIDTH'(DEPTH);

  // Pin synchronisers.
  logic [COLUMNS-1:0]       ready_meta;
  logic [COLUMNS-1:0]       ready_sync;
  logic [COLUMNS-1:0]       valid_meta;
  logic [COLUMNS-1:0]       valid_sync;
  logic [COLUMNS*WIDTH-1:0] out_meta;
  logic [COLUMNS*WIDTH-1:0] out_sync;

  // Input buffer.
  logic                     buf_valid;
  logic                     buf_ready;
  logic [WIDTH-1:0]         buf_data;
  logic                     buf_push;
  logic                     buf_pop;
  logic [OCC_WIDTH-1:0]     occupancy;
  logic [OCC_WIDTH-1:0]     next_occupancy;
  logic                     next_src_ready;

  // Load machine.
  fifo_stack_host_pkg::load_state_type       load_state;
  fifo_stack_host_pkg::load_state_type       next_load_state;
  logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] load_timer;
  logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] next_load_timer;
  logic                                      next_parallel_load_strobe;
  logic [COLUMNS*WIDTH-1:0]                  next_stack_in_data;
  logic                                      next_load_busy;

  // Dump machine.
  fifo_stack_host_pkg::dump_state_type       dump_state;
  fifo_stack_host_pkg::dump_state_type       next_dump_state;
  logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] dump_timer;
  logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] next_dump_timer;
  logic                                      next_word_dump_strobe;
  logic                                      next_sink_valid;
  logic [WIDTH-1:0]                          next_sink_data;

  logic                                      all_ready;
  logic                                      all_busy;
  logic                                      all_valid;

  // Every column shows the given input-ready flag level.
  function automatic logic columns_all(input logic [COLUMNS-1:0] flags, input logic level);
    columns_all = (flags == {COLUMNS{level}});
  endfunction

  // Column 0 carries the word; the other columns mirror it.
  function automatic logic [COLUMNS*WIDTH-1:0] replicate(input logic [WIDTH-1:0] word);
    replicate = {COLUMNS{word}};
  endfunction

  // One more cycle has passed on a phase timer.
  function automatic logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] tick(
    input logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] timer
  );
    tick = timer + 1'b1;
  endfunction

  // A phase ends on the cycle whose tick reaches its limit.
  function automatic logic expired(
    input logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] timer,
    input logic [fifo_stack_host_pkg::TIMER_WIDTH-1:0] limit
  );
    expired = (tick(timer) >= limit);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ready_meta <= '0;
      ready_sync <= '0;
      valid_meta <= '0;
      valid_sync <= '0;
      out_meta   <= '0;
      out_sync   <= '0;
    end else begin
      ready_meta <= input_ready_flag_n;
      ready_sync <= ready_meta;
      valid_meta <= output_valid;
      valid_sync <= valid_meta;
      out_meta   <= stack_out_data;
      out_sync   <= out_meta;
    end
  end

  assign all_ready = columns_all(ready_sync, fifo_stack_host_pkg::INPUT_READY_ACTIVE);
  assign all_busy  = columns_all(ready_sync, ~fifo_stack_host_pkg::INPUT_READY_ACTIVE);
  assign all_valid = &valid_sync;

  word_buffer #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) word_buffer_i (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (buf_push),
    .in_ready  (),
    .in_data   (src_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // The buffer head is consumed only when a load starts.
  assign buf_ready = (load_state == fifo_stack_host_pkg::LOAD_IDLE) && !parallel_load_strobe && all_ready;
  assign buf_push  = src_valid && src_ready;
  assign buf_pop   = buf_valid && buf_ready;

  // Buffer fill is mirrored here so that src_ready leaves the block from a register.
  always_comb begin
    next_occupancy = occupancy;
    if (buf_push && !buf_pop) begin
      next_occupancy = occupancy + 1'b1;
    end else if (buf_pop && !buf_push) begin
      next_occupancy = occupancy - 1'b1;
    end
    next_src_ready = (next_occupancy != OCC_FULL);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      occupancy <= '0;
      src_ready <= 1'b1;
    end else begin
      occupancy <= next_occupancy;
      src_ready <= next_src_ready;
    end
  end

  always_comb begin
    next_load_state           = load_state;
    next_load_timer           = load_timer;
    next_parallel_load_strobe = parallel_load_strobe;
    next_stack_in_data        = stack_in_data;
    next_load_busy            = load_busy;
    case (load_state)
      fifo_stack_host_pkg::LOAD_IDLE: begin
        next_load_busy = 1'b0;
        // Ready only while the strobe is low and all columns are ready.
        if (buf_valid && !parallel_load_strobe && all_ready) begin
          next_stack_in_data        = replicate(buf_data);
          next_load_timer           = '0;
          next_load_busy            = 1'b1;
          next_load_state           = fifo_stack_host_pkg::LOAD_STROBE;
        end
      end
      fifo_stack_host_pkg::LOAD_STROBE: begin
        // The word has stood on the pins for a cycle before the strobe rises.
        next_parallel_load_strobe = 1'b1;
        next_load_timer           = tick(load_timer);
        if (expired(load_timer, LOAD_HIGH_COUNT)) begin
          next_load_state = fifo_stack_host_pkg::LOAD_HOLD;
        end
      end
      fifo_stack_host_pkg::LOAD_HOLD: begin
        // Data stays put for the worst-case capture window after the rising edge.
        next_load_timer = tick(load_timer);
        if (expired(load_timer, HOLD_COUNT)) begin
          next_load_state = fifo_stack_host_pkg::LOAD_WAIT_BUSY;
        end
      end
      fifo_stack_host_pkg::LOAD_WAIT_BUSY: begin
        // A full column keeps input-ready busy; a later dump frees it.
        if (all_busy) begin
          next_parallel_load_strobe = 1'b0;
          next_load_state           = fifo_stack_host_pkg::LOAD_IDLE;
        end
      end
      default: begin
        next_load_state = fifo_stack_host_pkg::LOAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_state           <= fifo_stack_host_pkg::LOAD_IDLE;
      load_timer           <= '0;
      parallel_load_strobe <= 1'b0;
      stack_in_data        <= '0;
      load_busy            <= 1'b0;
    end else begin
      load_state           <= next_load_state;
      load_timer           <= next_load_timer;
      parallel_load_strobe <= next_parallel_load_strobe;
      stack_in_data        <= next_stack_in_data;
      load_busy            <= next_load_busy;
    end
  end

  always_comb begin
    next_dump_state       = dump_state;
    next_dump_timer       = dump_timer;
    next_word_dump_strobe = word_dump_strobe;
    next_sink_valid       = sink_valid;
    next_sink_data        = sink_data;
    case (dump_state)
      fifo_stack_host_pkg::DUMP_IDLE: begin
        if (all_valid) begin
          next_sink_valid = 1'b1;
          next_sink_data  = out_sync[WIDTH-1:0];
          next_dump_state = fifo_stack_host_pkg::DUMP_OFFER;
        end
      end
      fifo_stack_host_pkg::DUMP_OFFER: begin
        if (sink_ready) begin
          next_sink_valid       = 1'b0;
          next_word_dump_strobe = 1'b1;
          next_dump_timer       = '0;
          next_dump_state       = fifo_stack_host_pkg::DUMP_HIGH;
        end
      end
      fifo_stack_host_pkg::DUMP_HIGH: begin
        next_dump_timer = tick(dump_timer);
        if (expired(dump_timer, DUMP_HIGH_COUNT)) begin
          next_word_dump_strobe = 1'b0;
          next_dump_timer       = '0;
          next_dump_state       = fifo_stack_host_pkg::DUMP_LOW;
        end
      end
      fifo_stack_host_pkg::DUMP_LOW: begin
        // Let stale output-valid drain through the synchroniser before sampling again.
        next_dump_timer = tick(dump_timer);
        if (expired(dump_timer, DUMP_LOW_COUNT)) begin
          next_dump_state = fifo_stack_host_pkg::DUMP_IDLE;
        end
      end
      default: begin
        next_dump_state = fifo_stack_host_pkg::DUMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dump_state       <= fifo_stack_host_pkg::DUMP_IDLE;
      dump_timer       <= '0;
      word_dump_strobe <= 1'b0;
      sink_valid       <= 1'b0;
      sink_data        <= '0;
    end else begin
      dump_state       <= next_dump_state;
      dump_timer       <= next_dump_timer;
      word_dump_strobe <= next_word_dump_strobe;
      sink_valid       <= next_sink_valid;
      sink_data        <= next_sink_data;
    end
  end

endmodule

// File: tb/fifo_column_model.sv
// Behavioural model of one column of cascaded fall-through FIFO devices.
`timescale 1ns/1ps
module fifo_column_model #(
  parameter int WIDTH    = 8,
  parameter int CAPACITY = 125,
  parameter int CAPTURE  = 8,
  parameter int FALL     = 4
) (
  // Timing clock.
  input  wire logic             clk_sys,
  // Load side.
  input  wire logic             load_strobe,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  ready_n,
  // Dump side.
  input  wire logic             dump_strobe,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] words[$];
  int               load_cnt = 0;
  int               free_cnt = 0;
  int               show_cnt = 0;
  logic             dump_q   = 1'b0;

  initial begin
    ready_n = 1'b0;
    out_valid = 1'b0;
    out_data = '1;
  end

  // The chain is one queue; duplication at device boundaries caps it below the raw sum.
  always @(posedge clk_sys) begin
    load_cnt = load_strobe ? load_cnt + 1 : 0;
    free_cnt = (!load_strobe && ready_n && words.size() < CAPACITY) ? free_cnt + 1 : 0;
    show_cnt = (!dump_strobe && !out_valid && words.size() > 0) ? show_cnt + 1 : 0;
    if (load_cnt == CAPTURE && !ready_n) begin
      words.push_back(in_data);
      ready_n <= 1'b1;
    end
    if (free_cnt == FALL) ready_n <= 1'b0;
    if (dump_strobe && !dump_q) out_valid <= 1'b0;
    if (!dump_strobe && dump_q && words.size() > 0) begin
      words.delete(0);
      out_data <= ~out_data;
    end
    if (show_cnt == FALL) begin
      out_valid <= 1'b1;
      out_data <= words[0];
    end
    dump_q <= dump_strobe;
  end
endmodule

// File: tb/fifo_stack_host_checker.sv
// Concurrent assertions on the ports of the FIFO stack host controller.
`timescale 1ns/1ps
module fifo_stack_host_checker #(
  parameter int COLUMNS = 2,
  parameter int WIDTH   = 8
) (
  // Watched ports.
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire logic                     sink_valid,
  input wire logic                     sink_ready,
  input wire logic [WIDTH-1:0]         sink_data,
  input wire logic                     parallel_load_strobe,
  input wire logic [COLUMNS*WIDTH-1:0] stack_in_data,
  input wire logic [COLUMNS-1:0]       input_ready_flag_n,
  input wire logic                     word_dump_strobe,
  input wire logic [COLUMNS-1:0]       output_valid,
  input wire logic                     load_busy
);
  logic [8:0] load_high;
  logic [8:0] dump_high;
  logic [8:0] since_load;
  logic       strobe_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_high <= 9'h000;
      dump_high <= 9'h000;
      since_load <= 9'h1FF;
      strobe_q <= 1'b0;
    end else begin
      load_high <= parallel_load_strobe ? load_high + 9'h001 : 9'h000;
      dump_high <= word_dump_strobe ? dump_high + 9'h001 : 9'h000;
      strobe_q <= parallel_load_strobe;
      if (parallel_load_strobe && !strobe_q) since_load <= 9'h000;
      else if (since_load != 9'h1FF) since_load <= since_load + 9'h001;
    end
  end

  load_when_ready_a: assert property ($rose(parallel_load_strobe) |->
    $past(input_ready_flag_n, 4) == '0 && load_busy) else $error("load started while a column was busy");
  load_release_a: assert property ($fell(parallel_load_strobe) |->
    load_high >= fifo_stack_host_pkg::LOAD_HIGH_CYCLES && &$past(input_ready_flag_n, 3))
    else $error("load strobe dropped too early");
  data_hold_a: assert property ($changed(stack_in_data) |-> !parallel_load_strobe &&
    since_load >= fifo_stack_host_pkg::DATA_HOLD_CYCLES - 1) else $error("stack input data changed too soon");
  dump_after_take_a: assert property ($rose(word_dump_strobe) |->
    $past(sink_valid && sink_ready)) else $error("dump without an accepted word");
  dump_width_a: assert property ($fell(word_dump_strobe) |->
    dump_high >= fifo_stack_host_pkg::DUMP_HIGH_CYCLES) else $error("dump strobe too short");
  offer_when_valid_a: assert property ($rose(sink_valid) |->
    &$past(output_valid, 3) && !word_dump_strobe) else $error("word offered before all columns valid");
  offer_hold_a: assert property (sink_valid && !sink_ready |=>
    sink_valid && $stable(sink_data)) else $error("offered word not held");
  accept_dump_a: assert property (sink_valid && sink_ready |=>
    !sink_valid && word_dump_strobe) else $error("accepted word not dumped");
endmodule

bind fifo_stack_host fifo_stack_host_checker #(.COLUMNS(COLUMNS), .WIDTH(WIDTH)) fifo_stack_host_checker_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .sink_valid(sink_valid),
  .sink_ready(sink_ready),
  .sink_data(sink_data),
  .parallel_load_strobe(parallel_load_strobe),
  .stack_in_data(stack_in_data),
  .input_ready_flag_n(input_ready_flag_n),
  .word_dump_strobe(word_dump_strobe),
  .output_valid(output_valid),
  .load_busy(load_busy)
);

// File: tb/fifo_stack_host_tb_top.sv
// Self-checking testbench for the FIFO stack host controller with a two-column stack model.
`timescale 1ns/1ps
module fifo_stack_host_tb_top;
  localparam int W     = fifo_stack_host_pkg::WORD_WIDTH;
  localparam int C     = fifo_stack_host_pkg::STACK_COLUMNS;
  localparam int TOTAL = fifo_stack_host_pkg::STACK_CAPACITY + fifo_stack_host_pkg::BUFFER_DEPTH;

  logic           clk_sys;
  logic           rst;
  logic           src_valid;
  logic           src_ready;
  logic [W-1:0]   src_data;
  logic           sink_valid;
  logic           sink_ready;
  logic [W-1:0]   sink_data;
  logic           parallel_load_strobe;
  logic [C*W-1:0] stack_in_data;
  logic [C-1:0]   input_ready_flag_n;
  logic           word_dump_strobe;
  logic [C-1:0]   output_valid;
  logic [C*W-1:0] stack_out_data;
  logic           load_busy;
  int             errors = 0;
  int             comparisons = 0;
  int             cycles = 0;
  logic [W-1:0]   expq[$];

  fifo_stack_host fifo_stack_host_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .src_valid(src_valid),
    .src_ready(src_ready),
    .src_data(src_data),
    .sink_valid(sink_valid),
    .sink_ready(sink_ready),
    .sink_data(sink_data),
    .parallel_load_strobe(parallel_load_strobe),
    .stack_in_data(stack_in_data),
    .input_ready_flag_n(input_ready_flag_n),
    .word_dump_strobe(word_dump_strobe),
    .output_valid(output_valid),
    .stack_out_data(stack_out_data),
    .load_busy(load_busy)
  );

  // Columns share only the load and dump strobes; the second one falls through more slowly.
  for (genvar c = 0; c < C; c++) begin : col
    fifo_column_model #(.WIDTH(W), .CAPACITY(fifo_stack_host_pkg::STACK_CAPACITY), .FALL(4 + 5 * c))
      fifo_column_model_i (
      .clk_sys(clk_sys),
      .load_strobe(parallel_load_strobe),
      .in_data(stack_in_data[c*W +: W]),
      .ready_n(input_ready_flag_n[c]),
      .dump_strobe(word_dump_strobe),
      .out_valid(output_valid[c]),
      .out_data(stack_out_data[c*W +: W])
    );
  end

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic push(input logic [W-1:0] w);
    int n;
    n = 0;
    src_valid = 1'b1;
    src_data = w;
    while (src_ready !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n < 4000), 32'h1);
    expq.push_back(w);
    @(negedge clk_sys);
  endtask

  task automatic pull(input int stall);
    int n;
    logic [W-1:0] e;
    n = 0;
    while (sink_valid !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (stall) @(negedge clk_sys);
    e = expq.pop_front();
    check(32'({n < 4000, sink_data}), 32'({1'b1, e}));
    sink_ready = 1'b1;
    @(negedge clk_sys);
    sink_ready = 1'b0;
  endtask

  task automatic t_reset;
    check(32'({src_ready, sink_valid, parallel_load_strobe, word_dump_strobe, load_busy}), 32'h10);
  endtask

  task automatic t_single;
    push(8'hA5);
    src_valid = 1'b0;
    pull(0);
    check(32'(stack_in_data), 32'hA5A5);
  endtask

  task automatic t_fill;
    for (int i = 0; i < TOTAL; i++) push(8'(i * 7 + 3));
    src_valid = 1'b0;
    repeat (3000) @(negedge clk_sys);
    check(32'(src_ready), 32'h0);
    check(32'(col[0].fifo_column_model_i.words.size()), 32'(fifo_stack_host_pkg::STACK_CAPACITY));
    for (int i = 0; i < TOTAL; i++) pull(i % 3);
  endtask

  initial begin
    src_valid = 1'b0;
    src_data = '0;
    sink_ready = 1'b0;
    rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_single();
    t_fill();
    results();
  end
endmodule
